/* acr_defines.vh */
// Constants for the converter configuration and result register block
`ifndef ACR_DEFINES_VH
`define ACR_DEFINES_VH

// Register pointer values
`define ACR_PTR_RESULT  8'h00
`define ACR_PTR_CONFIG  8'h01

// Reset values
`define ACR_CFG_RESET   16'h8583
`define ACR_RES_RESET   16'h0000

// Configuration field positions
`define ACR_START_BIT   15
`define ACR_MUX_HI      14
`define ACR_MUX_LO      12
`define ACR_GAIN_HI     11
`define ACR_GAIN_LO     9
`define ACR_MODE_BIT    8
`define ACR_RATE_HI     7
`define ACR_RATE_LO     5
`define ACR_RSV_HI      4
`define ACR_RSV_LO      0

// Result field: 12 data bits left justified, low nibble zero
`define ACR_RES_PAD     4'h0

// Field values
`define ACR_MUX_SINGLE  3'h0
`define ACR_GAIN_FIXED  3'h2
`define ACR_GAIN_MIN    3'h5
`define ACR_NEG_GND     3'h4
`define ACR_MODE_CONT   1'b0

// Data rates in samples per second
`define ACR_SPS_0       128
`define ACR_SPS_1       250
`define ACR_SPS_2       490
`define ACR_SPS_3       920
`define ACR_SPS_4       1600
`define ACR_SPS_5       2400
`define ACR_SPS_6       3300

// Core clock rate in hertz
`define ACR_CLK_HZ      40000000

`endif

/* acr_host_model.sv */
// Host controller model issuing register transactions
`timescale 1ns/1ps
`default_nettype none
module acr_host_model (
   input  wire logic       core_clk,    // Clock
   input  wire logic [7:0] rd_byte_ff,  // Byte out
   input  wire logic       rd_valid_ff, // Byte valid
   output var  logic       xfer_start,  // Start
   output var  logic       xfer_write,  // Direction
   output var  logic       wr_valid,    // Byte strobe
   output var  logic [7:0] wr_byte,     // Byte in
   output var  logic       rd_req       // Byte request
);
   // Bus idle at time zero
   initial
   begin
      {xfer_start, xfer_write, wr_valid, rd_req} = 4'h0;
      wr_byte = 8'h5a;
   end
   // Opens a transaction
   task automatic open_xfer(input logic wr);
      @(posedge core_clk);
      xfer_start <= 1'b1;
      xfer_write <= wr;
      @(posedge core_clk);
      xfer_start <= 1'b0;
   endtask
   // Sends one byte; calls may follow back to back
   task automatic put(input logic [7:0] b);
      wr_valid <= 1'b1;
      wr_byte <= b;
      @(posedge core_clk);
   endtask
   // Writes the configuration register; released data lines do not hold
   task automatic wr_cfg(input logic [15:0] d);
      open_xfer(1'b1);
      put(8'h01);
      put(d[15:8]);
      put({d[7:5], 5'h03});
      wr_valid <= 1'b0;
      wr_byte <= ~wr_byte;
   endtask
   // Fetches one byte under a bounded wait
   task automatic get(output logic [7:0] b);
      int i;
      rd_req <= 1'b1;
      @(posedge core_clk);
      rd_req <= 1'b0;
      for (i = 0; i < 4 && rd_valid_ff !== 1'b1; i++) @(negedge core_clk);
      if (i == 4) test_adc_config_and_result_registers.hang();
      b = rd_byte_ff;
      @(posedge core_clk);
   endtask
   // Points at a register and reads it, high byte first
   task automatic rd_reg(input logic [7:0] p, output logic [15:0] d);
      open_xfer(1'b1);
      put(p);
      wr_valid <= 1'b0;
      wr_byte <= ~wr_byte;
      open_xfer(1'b0);
      get(d[15:8]);
      get(d[7:0]);
   endtask
endmodule // acr_host_model
`default_nettype wire

/* acr_regs.v */
// Configuration and result registers with conversion sequencing
// Summary of operation
// - Result holds 12 bits, low nibble zero
// - Config at pointer 01h, resets 8583h
// - Writing 1 starts one conversion when idle
// - Status reads 0 busy, 1 idle
// - Input select routes inputs per code
// - Single-channel variant holds input select 000
// - Gain range code selects full scale
// - No-gain variant holds gain range 010
// - Mode 0 continuous, 1 single-shot (default)
// - Rate select sets conversion period
// - Result at pointer 00h
// - Result zero until first conversion done
// - Status reads 0 in continuous mode
`include "acr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module acr_regs #(
   parameter [0:0] HAS_MUX  = 1'b1,          // Four-input variant
   parameter [0:0] HAS_GAIN = 1'b1,          // Programmable gain variant
   parameter       CLK_HZ   = `ACR_CLK_HZ    // Lower to shorten conversions
) (
   input  wire        core_clk,               // Core clock
   input  wire        rst_n,                  // Synchronous reset, active low
   input  wire        gcall_reset,            // General-call reset pulse
   input  wire        xfer_start,             // Transaction start pulse
   input  wire        xfer_write,             // Direction with xfer_start, 1 = write
   input  wire        wr_valid,               // Received byte strobe
   input  wire [7:0]  wr_byte,                // Received byte
   input  wire        rd_req,                 // Request next read byte
   input  wire [11:0] sample_data,            // Converter result at conversion end
   output reg  [7:0]  rd_byte_ff,             // Read byte
   output reg         rd_valid_ff,            // Read byte valid pulse
   output reg  [1:0]  pos_input_ff,           // Positive input selection
   output reg  [2:0]  neg_input_ff,           // Negative input, 4 = ground
   output reg  [2:0]  full_scale_range_ff,    // Gain range code in effect
   output reg  [2:0]  rate_select_ff,         // Data rate code in effect
   output reg         conv_active_ff,         // Conversion in progress
   output reg         conv_done_ff            // Result updated pulse
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_CONV = 2'h1;

   reg  [1:0]  st_ff;
   reg  [18:0] cnt_ff;
   reg  [15:0] cfg_ff;
   reg  [15:0] result_ff;
   reg  [7:0]  register_pointer_ff;
   reg  [7:0]  wr_msb_ff;
   reg  [1:0]  byte_cnt_ff;
   reg         xfer_wr_ff;
   reg  [15:0] rd_shadow_ff;
   reg         rd_idx_ff;

   wire        mode_single;
   wire        conv_start_status;
   wire        commit;
   wire [15:0] wr_word;
   wire [2:0]  nxt_mux;
   wire [2:0]  nxt_gain;
   wire        idle_pd;
   wire        start_single;
   wire        start_cont;
   wire        conv_end;

   // Conversion period in core cycles for a rate code
   function [18:0] conv_cycles;
      input [2:0] rate_code;
      integer sps;
      integer cyc;
      begin
         case (rate_code)
            3'h0:    sps = `ACR_SPS_0;
            3'h1:    sps = `ACR_SPS_1;
            3'h2:    sps = `ACR_SPS_2;
            3'h3:    sps = `ACR_SPS_3;
            3'h4:    sps = `ACR_SPS_4;
            3'h5:    sps = `ACR_SPS_5;
            default: sps = `ACR_SPS_6;
         endcase
         cyc = CLK_HZ / sps;
         if (cyc < 1)
         begin
            cyc = 1;
         end
         conv_cycles = cyc[18:0];
      end
   endfunction

   // Register contents as the host reads them
   function [15:0] read_value;
      input [7:0]  ptr;
      input [15:0] cfg;
      input [15:0] res;
      input        status_rd;
      begin
         if (ptr == `ACR_PTR_RESULT)
         begin
            read_value = {res[15:4], `ACR_RES_PAD};
         end
         else if (ptr == `ACR_PTR_CONFIG)
         begin
            read_value = {status_rd, cfg[14:0]};
         end
         else
         begin
            read_value = 16'h0000;
         end
      end
   endfunction

   // Mode and status decode
   assign mode_single       = cfg_ff[`ACR_MODE_BIT];
   assign conv_start_status = mode_single & (st_ff == ST_IDLE);

   // Write word commits on the second data byte to the config pointer
   assign commit  = wr_valid & xfer_wr_ff & (byte_cnt_ff == 2'h2)
                    & (register_pointer_ff == `ACR_PTR_CONFIG);
   assign wr_word = {wr_msb_ff, wr_byte};
   assign nxt_mux = HAS_MUX ? wr_word[`ACR_MUX_HI:`ACR_MUX_LO]
                            : `ACR_MUX_SINGLE;
   assign nxt_gain = HAS_GAIN ? wr_word[`ACR_GAIN_HI:`ACR_GAIN_LO]
                              : `ACR_GAIN_FIXED;

   // Start only from power-down in single-shot; zero has no effect
   assign idle_pd      = (st_ff == ST_IDLE) & mode_single;
   assign start_single = commit & wr_word[`ACR_START_BIT] & idle_pd;
   assign start_cont   = (st_ff == ST_IDLE) & ~mode_single;
   assign conv_end     = (st_ff == ST_CONV) & (cnt_ff == 19'h00001);

   // Configuration register, host writes
   always @(posedge core_clk)
   begin
      if (!rst_n || gcall_reset)
      begin
         cfg_ff <= `ACR_CFG_RESET;
      end
      else if (commit)
      begin
         // Reserved bits stored as written; host supplies 03h
         cfg_ff <= {1'b1, nxt_mux, nxt_gain, wr_word[`ACR_MODE_BIT],
                    wr_word[`ACR_RATE_HI:`ACR_RATE_LO],
                    wr_word[`ACR_RSV_HI:`ACR_RSV_LO]};
      end
   end

   // Conversion sequencer
   always @(posedge core_clk)
   begin
      if (!rst_n || gcall_reset)
      begin
         st_ff        <= ST_IDLE;
         cnt_ff       <= 19'h00000;
         conv_done_ff <= 1'b0;
      end
      else
      begin
         conv_done_ff <= 1'b0;
         case (st_ff)
            ST_IDLE:
            begin
               if (start_single)
               begin
                  // A start that also sets the rate must run at the new rate
                  st_ff  <= ST_CONV;
                  cnt_ff <= conv_cycles(wr_word[`ACR_RATE_HI:`ACR_RATE_LO]);
               end
               else if (start_cont)
               begin
                  st_ff  <= ST_CONV;
                  cnt_ff <= conv_cycles(cfg_ff[`ACR_RATE_HI:`ACR_RATE_LO]);
               end
            end
            ST_CONV:
            begin
               if (conv_end)
               begin
                  conv_done_ff <= 1'b1;
                  if (!mode_single)
                  begin
                     cnt_ff <= conv_cycles(cfg_ff[`ACR_RATE_HI:`ACR_RATE_LO]);
                  end
                  else
                  begin
                     st_ff <= ST_IDLE;
                  end
               end
               else
               begin
                  cnt_ff <= cnt_ff - 19'h00001;
               end
            end
            default:
            begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // Result register, zero until the first conversion completes
   always @(posedge core_clk)
   begin
      if (!rst_n || gcall_reset)
      begin
         result_ff <= `ACR_RES_RESET;
      end
      else if (conv_end)
      begin
         result_ff <= {sample_data, `ACR_RES_PAD};
      end
   end

   // Pointer and write byte tracking
   always @(posedge core_clk)
   begin
      if (!rst_n || gcall_reset)
      begin
         register_pointer_ff <= `ACR_PTR_RESULT;
         wr_msb_ff           <= 8'h00;
         byte_cnt_ff         <= 2'h0;
         xfer_wr_ff          <= 1'b0;
      end
      else if (xfer_start)
      begin
         byte_cnt_ff <= 2'h0;
         xfer_wr_ff  <= xfer_write;
      end
      else if (wr_valid && xfer_wr_ff)
      begin
         case (byte_cnt_ff)
            2'h0:    register_pointer_ff <= wr_byte;
            2'h1:    wr_msb_ff <= wr_byte;
            default: wr_msb_ff <= wr_msb_ff;
         endcase
         if (byte_cnt_ff != 2'h3)
         begin
            byte_cnt_ff <= byte_cnt_ff + 2'h1;
         end
      end
   end

   // Read path: snapshot at read start, MSB first then LSB
   always @(posedge core_clk)
   begin
      if (!rst_n || gcall_reset)
      begin
         rd_shadow_ff <= 16'h0000;
         rd_idx_ff    <= 1'b0;
         rd_byte_ff   <= 8'h00;
         rd_valid_ff  <= 1'b0;
      end
      else
      begin
         rd_valid_ff <= 1'b0;
         if (xfer_start && !xfer_write)
         begin
            rd_shadow_ff <= read_value(register_pointer_ff, cfg_ff, result_ff,
                                       conv_start_status);
            rd_idx_ff    <= 1'b0;
         end
         else if (rd_req)
         begin
            rd_byte_ff  <= rd_idx_ff ? rd_shadow_ff[7:0] : rd_shadow_ff[15:8];
            rd_valid_ff <= 1'b1;
            rd_idx_ff   <= ~rd_idx_ff;
         end
      end
   end

   // Analog front-end controls decoded from configuration
   always @(posedge core_clk)
   begin
      if (!rst_n || gcall_reset)
      begin
         pos_input_ff        <= 2'h0;
         neg_input_ff        <= 3'h1;
         full_scale_range_ff <= `ACR_GAIN_FIXED;
         rate_select_ff      <= 3'h4;
         conv_active_ff      <= 1'b0;
      end
      else
      begin
         conv_active_ff <= (st_ff == ST_CONV) & ~conv_end;
         rate_select_ff <= cfg_ff[`ACR_RATE_HI:`ACR_RATE_LO];
         case (cfg_ff[`ACR_MUX_HI:`ACR_MUX_LO])
            3'h0:
            begin
               pos_input_ff <= 2'h0;
               neg_input_ff <= 3'h1;
            end
            3'h1, 3'h2, 3'h3:
            begin
               pos_input_ff <= cfg_ff[13:12] - 2'h1;
               neg_input_ff <= 3'h3;
            end
            default:
            begin
               pos_input_ff <= cfg_ff[13:12];
               neg_input_ff <= `ACR_NEG_GND;
            end
         endcase
         if (cfg_ff[`ACR_GAIN_HI:`ACR_GAIN_LO] > `ACR_GAIN_MIN)
         begin
            full_scale_range_ff <= `ACR_GAIN_MIN;
         end
         else
         begin
            full_scale_range_ff <= cfg_ff[`ACR_GAIN_HI:`ACR_GAIN_LO];
         end
      end
   end

endmodule // acr_regs

`default_nettype wire

/* acr_regs_chk.sv */
// Assertion checker for the converter register block
`timescale 1ns/1ps
`default_nettype none
module acr_regs_chk (
   input wire logic       core_clk,            // Clock
   input wire logic       rst_n,               // Reset
   input wire logic       gcall_reset,         // Soft reset
   input wire logic       xfer_start,          // Start
   input wire logic       wr_valid,            // Byte strobe
   input wire logic       rd_req,              // Byte request
   input wire logic [7:0] rd_byte_ff,          // Byte out
   input wire logic       rd_valid_ff,         // Byte valid
   input wire logic [1:0] pos_input_ff,        // Positive input
   input wire logic [2:0] neg_input_ff,        // Negative input
   input wire logic [2:0] full_scale_range_ff, // Gain code
   input wire logic [2:0] rate_select_ff,      // Rate code
   input wire logic       conv_active_ff,      // Busy
   input wire logic       conv_done_ff         // Done pulse
);
   // All checks share the core clock and its reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   rd_answer_a: assert property (rd_req && !xfer_start |=> rd_valid_ff)
      else $error("read request not answered");
   rd_quiet_a: assert property (!rd_req |=> !rd_valid_ff)
      else $error("read byte without request");
   rd_hold_a: assert property (!rd_valid_ff && !$past(gcall_reset) |-> $stable(rd_byte_ff))
      else $error("read byte changed without valid");
   done_pulse_a: assert property (conv_done_ff |=> !conv_done_ff)
      else $error("done pulse too long");
   done_end_a: assert property (conv_done_ff |-> !conv_active_ff && $past(conv_active_ff))
      else $error("done without a conversion");
   range_fold_a: assert property (full_scale_range_ff <= 3'h5)
      else $error("gain code out of range");
   mux_route_a: assert property (neg_input_ff == 3'h4 || neg_input_ff == 3'h3 && pos_input_ff != 2'h3
      || pos_input_ff == 2'h0 && neg_input_ff == 3'h1)
      else $error("illegal input pairing");
   cfg_hold_a: assert property (!wr_valid && !$past(wr_valid) && !$past(wr_valid, 2) && !gcall_reset
      |=> $stable({rate_select_ff, full_scale_range_ff, neg_input_ff}))
      else $error("settings changed without a write");
   cover property (rd_valid_ff);
   cover property (conv_done_ff);
   cover property (full_scale_range_ff == 3'h5);
endmodule // acr_regs_chk
bind acr_regs acr_regs_chk u_acr_regs_chk (.core_clk, .rst_n, .gcall_reset, .xfer_start,
   .wr_valid, .rd_req, .rd_byte_ff, .rd_valid_ff, .pos_input_ff, .neg_input_ff,
   .full_scale_range_ff, .rate_select_ff, .conv_active_ff, .conv_done_ff);
`default_nettype wire

/* test_adc_config_and_result_registers.sv */
// Self-checking bench for the converter register block
`timescale 1ns/1ps
`default_nettype none
module test_adc_config_and_result_registers;
   logic        core_clk, rst_n, gcall_reset, xfer_start, xfer_write, wr_valid, rd_req;
   logic        rd_valid_ff, conv_active_ff, conv_done_ff;
   logic [7:0]  wr_byte, rd_byte_ff;
   logic [11:0] sample_data;
   logic [1:0]  pos_input_ff;
   logic [2:0]  neg_input_ff, full_scale_range_ff, rate_select_ff, c;
   logic [15:0] d, port_word;
   logic [4:0]  route [8] = '{5'h01, 5'h03, 5'h0b, 5'h13, 5'h04, 5'h0c, 5'h14, 5'h1c};
   int          n_fail = 0, n_compared = 0, n_done = 0;
   // Setting outputs packed for comparison
   assign port_word = {4'h0, conv_active_ff, pos_input_ff, neg_input_ff,
                       full_scale_range_ff, rate_select_ff};
   acr_regs #(.CLK_HZ(25600)) u_acr_regs (.core_clk, .rst_n, .gcall_reset, .xfer_start,
      .xfer_write, .wr_valid, .wr_byte, .rd_req, .sample_data, .rd_byte_ff, .rd_valid_ff,
      .pos_input_ff, .neg_input_ff, .full_scale_range_ff, .rate_select_ff,
      .conv_active_ff, .conv_done_ff);
   acr_host_model u_acr_host_model (.core_clk, .rd_byte_ff, .rd_valid_ff, .xfer_start,
      .xfer_write, .wr_valid, .wr_byte, .rd_req);
   // 40 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Counts result updates
   always @(posedge core_clk) if (conv_done_ff === 1'b1) n_done++;
   // Compares one value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Prints the verdict and stops
   task automatic complete_run;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // A wait ran out
   task automatic hang;
      n_fail++;
      complete_run();
   endtask
   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      gcall_reset = 1'b0;
      sample_data = 12'ha5c;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      u_acr_host_model.rd_reg(8'h01, d);
      chk(d, 16'h8583);
      u_acr_host_model.rd_reg(8'h00, d);
      chk(d, 16'h0000);
      chk(port_word, 16'h0054);
      // Every code of the input, gain and rate fields, mode written as one, start bit written as zero
      for (int k = 0; k < 8; k++)
      begin
         c = 3'(k);
         u_acr_host_model.wr_cfg({1'b0, c, c, 1'b1, c, 5'h03});
         u_acr_host_model.rd_reg(8'h01, d);
         chk(d, {1'b1, c, c, 1'b1, c, 5'h03});
         chk(port_word, {5'h0, route[k], (c > 3'h5) ? 3'h5 : c, c});
      end
      // Single shot at the slowest rate, second start while busy
      n_done = 0;
      u_acr_host_model.wr_cfg(16'h8503);
      u_acr_host_model.rd_reg(8'h01, d);
      chk(d, 16'h0503);
      chk(port_word, 16'h0850);
      u_acr_host_model.wr_cfg(16'h8503);
      u_acr_host_model.rd_reg(8'h01, d);
      chk(d, 16'h0503);
      for (int i = 0; i < 400 && n_done == 0; i++) @(posedge core_clk);
      if (n_done == 0) hang();
      repeat (300) @(posedge core_clk);
      chk(16'(n_done), 16'h0001);
      u_acr_host_model.rd_reg(8'h00, d);
      chk(d, 16'ha5c0);
      u_acr_host_model.rd_reg(8'h01, d);
      chk(d, 16'h8503);
      // Continuous mode, then back to single shot
      u_acr_host_model.wr_cfg(16'h04e3);
      u_acr_host_model.rd_reg(8'h01, d);
      chk(d, 16'h04e3);
      n_done = 0;
      repeat (40) @(posedge core_clk);
      chk(16'(n_done > 2), 16'h0001);
      u_acr_host_model.wr_cfg(16'h05e3);
      repeat (20) @(posedge core_clk);
      u_acr_host_model.rd_reg(8'h01, d);
      chk(d, 16'h85e3);
      // General-call reset restores defaults
      gcall_reset <= 1'b1;
      @(posedge core_clk);
      gcall_reset <= 1'b0;
      u_acr_host_model.rd_reg(8'h01, d);
      chk(d, 16'h8583);
      u_acr_host_model.rd_reg(8'h00, d);
      chk(d, 16'h0000);
      complete_run();
   end
endmodule // test_adc_config_and_result_registers
`default_nettype wire
